// ---- controller_config_sweep_defs.svh ----
// constants of the controller configuration, serial framing and scan block
`ifndef CONTROLLER_CONFIG_SWEEP_DEFS_SVH
`define CONTROLLER_CONFIG_SWEEP_DEFS_SVH
`define CLK_PERIOD_NS  4
`define CLK_HZ         250000000
`define MODEM_UNIT_MS  10
`define MODEM_UNIT_CYC (`MODEM_UNIT_MS * 1000000 / `CLK_PERIOD_NS)
`define SCAN_UNIT_MS   1
`define SCAN_UNIT_CYC  (`SCAN_UNIT_MS * 1000000 / `CLK_PERIOD_NS)
`define IDLE_UNIT_S    1
`define IDLE_UNIT_CYC  (`IDLE_UNIT_S * 1000000000 / `CLK_PERIOD_NS)
`define DIAG_CYC       1000
`define BAUD_R0        300
`define BAUD_R1        600
`define BAUD_R2        1200
`define BAUD_R3        2400
`define BAUD_R4        4800
`define BAUD_R5        9600
`define BAUD_R6        19200
`define BAUD_SEL_MAX   3'h6
`define OFF_SYS        8'h00
`define OFF_SERIAL     8'h04
`define OFF_MODEM      8'h08
`define OFF_IDLE       8'h0C
`define OFF_SCAN       8'h10
`define OFF_STATUS     8'h14
`define OFF_IRQ_EN     8'h18
`define OFF_IRQ_CLR    8'h1C
`define OFF_STATE      8'h20
`define SCAN_MODE_BIT  0
`define SCAN_PER_LSB   8
`define RST_SYS        7'h60
`define RST_SERIAL     7'h1E
`define RST_MODEM      8'h00
`define RST_IDLE       6'h0A
`define RST_PERIOD     8'h64
`define IDLE_MIN       6'h01
`define IDLE_MAX       6'h3C
`define PERIOD_MIN     8'h05
`define PERIOD_MAX     8'hC8
`define PWRUP_INVALID  2'h3
`define PARITY_INVALID 2'h3
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ---- controller_config_sweep_pkg.sv ----
// types of the controller configuration, serial framing and scan block
package controller_config_sweep_pkg;
  // pwrUpMode: 0 last, 1 stop, 2 run
  typedef struct packed {
    logic       selfTest;
    logic       passwords;
    logic       regsFlash;
    logic       cfgFlash;
    logic       ioScanStop;
    logic [1:0] pwrUpMode;
  } sys_cfg_t;
  // parity: 0 none, 1 odd, 2 even
  typedef struct packed {
    logic       twoStop;
    logic [1:0] parity;
    logic       eightBits;
    logic [2:0] baudSel;
  } serial_cfg_t;
  typedef struct packed {
    logic diagDone;
    logic expFault;
    logic scanOverrun;
    logic idleExpired;
  } events_t;
  typedef enum logic [2:0] {ST_BOOT, ST_DIAG, ST_WORK, ST_HOLD} scan_state_t;
endpackage

// ---- controller_config_serial_sweep.sv ----
// configuration bank, serial framing, modem delay, idle timer and scan pacing
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "controller_config_sweep_defs.svh"
module controller_config_serial_sweep #(
  parameter int unsigned MODEM_UNIT_CYCLES = `MODEM_UNIT_CYC,
  parameter int unsigned SCAN_UNIT_CYCLES  = `SCAN_UNIT_CYC,
  parameter int unsigned IDLE_UNIT_CYCLES  = `IDLE_UNIT_CYC,
  parameter int unsigned DIAG_CYCLES       = `DIAG_CYC
) (
  input  wire logic                                 mclk,
  input  wire logic                                 rstn,
  input  wire logic                                 ce,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [7:0]                           awaddr,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  output logic [1:0]                                bresp,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  input  wire logic [7:0]                           araddr,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  input  wire logic                                 runMode,
  input  wire logic                                 scanDone,
  input  wire logic                                 txReq,
  input  wire logic                                 rxMsg,
  input  wire logic                                 keySeq,
  input  wire logic                                 expPresent,
  output controller_config_sweep_pkg::sys_cfg_t    sysCfg,
  output controller_config_sweep_pkg::serial_cfg_t serialCfg,
  output logic [19:0]                               baudDiv,
  output logic                                      logicFromFlash,
  output logic                                      ioScanEn,
  output logic                                      scanStart,
  output logic                                      rts,
  output logic                                      txGo,
  output logic                                      sessionActive,
  output logic                                      sessionDrop,
  output logic                                      memClear,
  output logic                                      expFault,
  output logic                                      startupDone,
  output logic                                      irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state and helpers

  logic [7:0]                              modemTurnaroundSetting;
  logic [5:0]                              idleLimit;
  logic                                    fixedPeriodScan;
  logic [7:0]                              scanPeriod;
  controller_config_sweep_pkg::events_t    irqStatus;
  controller_config_sweep_pkg::events_t    irqEnable;
  controller_config_sweep_pkg::events_t    next_events;
  controller_config_sweep_pkg::scan_state_t scanState;
  localparam controller_config_sweep_pkg::scan_state_t
    ST_BOOT = controller_config_sweep_pkg::ST_BOOT,
    ST_DIAG = controller_config_sweep_pkg::ST_DIAG,
    ST_WORK = controller_config_sweep_pkg::ST_WORK,
    ST_HOLD = controller_config_sweep_pkg::ST_HOLD;
  logic [7:0]                              awAddrHeld;
  logic [31:0]                             wDataHeld;
  logic [3:0]                              wStrbHeld;
  logic                                    doWrite;
  logic [31:0]                             wrWord;
  logic [31:0]                             sweepCyc;
  logic                                    periodUp;
  logic [31:0]                             diagCnt;
  logic [31:0]                             modemCnt;
  logic [7:0]                              modemUnits;
  logic [31:0]                             idleCnt;
  logic [5:0]                              idleSecs;
  logic                                    keyTaken;
  logic                                    inStartup;
  logic                                    startNow;
  logic                                    overrunNow;
  logic                                    idleExpire;

  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0:    baud_div = 20'(`CLK_HZ / `BAUD_R0);
      3'h1:    baud_div = 20'(`CLK_HZ / `BAUD_R1);
      3'h2:    baud_div = 20'(`CLK_HZ / `BAUD_R2);
      3'h3:    baud_div = 20'(`CLK_HZ / `BAUD_R3);
      3'h4:    baud_div = 20'(`CLK_HZ / `BAUD_R4);
      3'h5:    baud_div = 20'(`CLK_HZ / `BAUD_R5);
      default: baud_div = 20'(`CLK_HZ / `BAUD_R6);
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `OFF_SYS) || (a == `OFF_SERIAL) || (a == `OFF_MODEM)
            || (a == `OFF_IDLE) || (a == `OFF_SCAN) || (a == `OFF_STATUS)
            || (a == `OFF_IRQ_EN) || (a == `OFF_IRQ_CLR) || (a == `OFF_STATE);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    reg_read = 32'h0000_0000;
    case (a)
      `OFF_SYS:    reg_read[6:0] = sysCfg;
      `OFF_SERIAL: reg_read[6:0] = serialCfg;
      `OFF_MODEM:  reg_read[7:0] = modemTurnaroundSetting;
      `OFF_IDLE:   reg_read[5:0] = idleLimit;
      `OFF_SCAN: begin
        reg_read[`SCAN_MODE_BIT] = fixedPeriodScan;
        reg_read[`SCAN_PER_LSB +: 8] = scanPeriod;
      end
      `OFF_STATUS: reg_read[3:0] = irqStatus;
      `OFF_IRQ_EN: reg_read[3:0] = irqEnable;
      `OFF_STATE:  reg_read[5:0] = {startupDone, sessionActive, rts, txGo,
                                     expFault, scanState == ST_HOLD};
      default:     reg_read = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // a write happens once both address and data are held and no response is pending
  assign doWrite = !awready && !wready && !bvalid;
  assign wrWord  = merge(reg_read(awAddrHeld), wDataHeld, wStrbHeld);

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      awAddrHeld <= 8'h00;
      wDataHeld  <= 32'h0000_0000;
      wStrbHeld  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awAddrHeld <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
        wready    <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= addr_hit(awAddrHeld) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= reg_read(araddr);
        rresp   <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sysCfg <= `RST_SYS;
    end else if (ce) begin
      if (doWrite && awAddrHeld == `OFF_SYS) begin
        sysCfg.ioScanStop <= wrWord[4'(2)];
        sysCfg.cfgFlash   <= wrWord[3];
        sysCfg.regsFlash  <= wrWord[4];
        sysCfg.selfTest   <= wrWord[6];
        if (wrWord[1:0] != `PWRUP_INVALID) begin
          sysCfg.pwrUpMode <= wrWord[1:0];
        end
        // software may only switch passwords off, never back on
        if (!wrWord[5]) begin
          sysCfg.passwords <= 1'b0;
        end
      end
      if (memClear) begin
        sysCfg.passwords <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serialCfg <= `RST_SERIAL;
    end else if (ce && doWrite && awAddrHeld == `OFF_SERIAL) begin
      if (wrWord[2:0] <= `BAUD_SEL_MAX) begin
        serialCfg.baudSel <= wrWord[2:0];
      end
      serialCfg.eightBits <= wrWord[3];
      if (wrWord[5:4] != `PARITY_INVALID) begin
        serialCfg.parity <= wrWord[5:4];
      end
      serialCfg.twoStop <= wrWord[6];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      modemTurnaroundSetting <= `RST_MODEM;
      idleLimit              <= `RST_IDLE;
      fixedPeriodScan        <= 1'b0;
      scanPeriod             <= `RST_PERIOD;
    end else if (ce && doWrite) begin
      if (awAddrHeld == `OFF_MODEM) begin
        modemTurnaroundSetting <= wrWord[7:0];
      end
      if (awAddrHeld == `OFF_IDLE && wrWord[5:0] >= `IDLE_MIN
          && wrWord[5:0] <= `IDLE_MAX) begin
        idleLimit <= wrWord[5:0];
      end
      if (awAddrHeld == `OFF_SCAN) begin
        fixedPeriodScan <= wrWord[`SCAN_MODE_BIT];
        // the period only takes a write that also selects fixed mode
        if (wrWord[`SCAN_MODE_BIT] && wrWord[`SCAN_PER_LSB +: 8] >= `PERIOD_MIN
            && wrWord[`SCAN_PER_LSB +: 8] <= `PERIOD_MAX) begin
          scanPeriod <= wrWord[`SCAN_PER_LSB +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      baudDiv        <= 20'h0_0000;
      logicFromFlash <= 1'b0;
      ioScanEn       <= 1'b0;
    end else if (ce) begin
      baudDiv        <= baud_div(serialCfg.baudSel);
      logicFromFlash <= 1'b1;
      ioScanEn       <= startupDone && (runMode || sysCfg.ioScanStop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a clear in the same cycle

  assign next_events.idleExpired = idleExpire;
  assign next_events.scanOverrun = overrunNow;
  assign next_events.expFault    = expPresent && !sysCfg.selfTest && !expFault;
  assign next_events.diagDone    = scanState == ST_DIAG && diagCnt == DIAG_CYCLES - 1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= 4'h0;
      irqEnable <= 4'h0;
      irq       <= 1'b0;
    end else if (ce) begin
      if (doWrite && awAddrHeld == `OFF_IRQ_EN) begin
        irqEnable <= wrWord[3:0];
      end
      if (doWrite && awAddrHeld == `OFF_IRQ_CLR) begin
        irqStatus <= (irqStatus & ~wDataHeld[3:0]) | next_events;
      end else begin
        irqStatus <= irqStatus | next_events;
      end
      irq <= |(irqStatus & irqEnable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // startup, diagnostics and scan pacing

  assign inStartup  = scanState == ST_BOOT || scanState == ST_DIAG;
  assign periodUp   = sweepCyc >= 32'(scanPeriod) * SCAN_UNIT_CYCLES - 1;
  assign overrunNow = scanState == ST_WORK && scanDone && fixedPeriodScan
                   && sweepCyc > 32'(scanPeriod) * SCAN_UNIT_CYCLES - 1;
  always_comb begin
    startNow = 1'b0;
    case (scanState)
      ST_BOOT: startNow = !sysCfg.selfTest;
      ST_DIAG: startNow = diagCnt == DIAG_CYCLES - 1;
      ST_WORK: startNow = scanDone && (!fixedPeriodScan || periodUp);
      ST_HOLD: startNow = periodUp;
      default: startNow = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scanState   <= ST_BOOT;
      scanStart   <= 1'b0;
      startupDone <= 1'b0;
      diagCnt     <= 32'h0000_0000;
      sweepCyc    <= 32'h0000_0000;
    end else if (ce) begin
      scanStart <= startNow;
      sweepCyc  <= startNow ? 32'h0000_0000 : sweepCyc + 32'h0000_0001;
      if (startNow) begin
        scanState   <= ST_WORK;
        startupDone <= 1'b1;
      end else begin
        case (scanState)
          ST_BOOT: scanState <= ST_DIAG;
          ST_DIAG: diagCnt <= diagCnt + 32'h0000_0001;
          ST_WORK: begin
            if (scanDone) begin
              scanState <= ST_HOLD;
            end
          end
          ST_HOLD: scanState <= ST_HOLD;
          default: scanState <= ST_BOOT;
        endcase
      end
    end
  end

  // key sequences count only once per startup, and only with self-test on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memClear <= 1'b0;
      keyTaken <= 1'b0;
      expFault <= 1'b0;
    end else if (ce) begin
      memClear <= inStartup && keySeq && sysCfg.selfTest && !keyTaken;
      if (inStartup && keySeq && sysCfg.selfTest) begin
        keyTaken <= 1'b1;
      end
      if (expPresent && !sysCfg.selfTest) begin
        expFault <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modem turnaround: a delay of zero lets data go one cycle after rts

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rts        <= 1'b0;
      txGo       <= 1'b0;
      modemCnt   <= 32'h0000_0000;
      modemUnits <= 8'h00;
    end else if (ce) begin
      if (!txReq) begin
        rts  <= 1'b0;
        txGo <= 1'b0;
      end else if (!rts) begin
        rts        <= 1'b1;
        modemCnt   <= 32'h0000_0000;
        modemUnits <= modemTurnaroundSetting;
      end else if (modemUnits == 8'h00) begin
        txGo <= 1'b1;
      end else if (modemCnt == MODEM_UNIT_CYCLES - 1) begin
        modemCnt   <= 32'h0000_0000;
        modemUnits <= modemUnits - 8'h01;
      end else begin
        modemCnt <= modemCnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // programmer idle timer

  assign idleExpire = sessionActive && !rxMsg && idleCnt == IDLE_UNIT_CYCLES - 1
                   && idleSecs == idleLimit - 6'h01;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sessionActive <= 1'b0;
      sessionDrop   <= 1'b0;
      idleCnt       <= 32'h0000_0000;
      idleSecs      <= 6'h00;
    end else if (ce) begin
      sessionDrop <= idleExpire;
      if (rxMsg) begin
        sessionActive <= 1'b1;
        idleCnt       <= 32'h0000_0000;
        idleSecs      <= 6'h00;
      end else if (idleExpire) begin
        sessionActive <= 1'b0;
        idleCnt       <= 32'h0000_0000;
        idleSecs      <= 6'h00;
      end else if (sessionActive) begin
        if (idleCnt == IDLE_UNIT_CYCLES - 1) begin
          idleCnt  <= 32'h0000_0000;
          idleSecs <= idleSecs + 6'h01;
        end else begin
          idleCnt <= idleCnt + 32'h0000_0001;
        end
      end
    end
  end

endmodule

// ---- cfg_sweep_chk.sv ----
// port checker of the configuration, serial framing and scan block
`timescale 1ns/100ps
module cfg_sweep_chk (
  input wire logic                                     mclk,
  input wire logic                                     rstn,
  input wire logic                                     ce,
  input wire logic                                     txReq,
  input wire logic                                     rts,
  input wire logic                                     txGo,
  input wire logic                                     sessionActive,
  input wire logic                                     sessionDrop,
  input wire logic                                     scanStart,
  input wire logic [19:0]                              baudDiv,
  input wire controller_config_sweep_pkg::serial_cfg_t serialCfg,
  input wire controller_config_sweep_pkg::sys_cfg_t    sysCfg,
  input wire logic                                     ioScanEn,
  input wire logic                                     startupDone,
  input wire logic                                     runMode,
  input wire logic                                     expPresent,
  input wire logic                                     expFault,
  input wire logic                                     logicFromFlash
);
  localparam int DIVS [7] = '{833333, 416666, 208333, 104166, 52083, 26041, 13020};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn || !ce);
  sequence txRise; $rose(txReq); endsequence
  sequence txFall; !txReq; endsequence
  AST_RTS_RISE: assert property (txRise |=> rts)
    else $error("rts not raised after transmit request");
  AST_RTS_DROP: assert property (txFall |=> !rts && !txGo)
    else $error("rts or txGo kept after request dropped");
  AST_TXGO_WAIT: assert property ($rose(txGo) |-> rts && $past(rts))
    else $error("txGo rose without a turnaround wait");
  AST_DROP_END: assert property ($rose(sessionDrop) |-> !sessionActive && $past(sessionActive))
    else $error("session drop without ending session");
  AST_SCAN_PULSE: assert property (scanStart |=> !scanStart)
    else $error("scanStart longer than one cycle");
  AST_BAUD_DIV: assert property (rstn |=> baudDiv == 20'(DIVS[$past(serialCfg.baudSel)]))
    else $error("baud divider does not match selected rate");
  AST_IO_SCAN: assert property (1 |=> ioScanEn == $past(startupDone && (runMode || sysCfg.ioScanStop)))
    else $error("io scan enable wrong");
  AST_EXP_LATCH: assert property (expPresent && !sysCfg.selfTest |-> ##[1:2] expFault)
    else $error("expansion fault not logged");
  AST_EXP_STICKY: assert property (expFault |=> expFault)
    else $error("expansion fault cleared");
  AST_LOGIC_FLASH: assert property (rstn |=> logicFromFlash)
    else $error("logic not taken from flash");
endmodule
bind controller_config_serial_sweep cfg_sweep_chk CHK (.mclk, .rstn, .ce, .txReq, .rts, .txGo,
  .sessionActive, .sessionDrop, .scanStart, .baudDiv, .serialCfg, .sysCfg, .ioScanEn,
  .startupDone, .runMode, .expPresent, .expFault, .logicFromFlash);

// ---- prog_device.sv ----
// programming device model: message strobes and power-up key sequence
`timescale 1ns/100ps
module prog_device (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic msgGo,
  input wire logic keyGo,
  output logic     rxMsg,
  output logic     keySeq
);
  logic seen;
  // one message per request edge, so a held request cannot look like a stream
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxMsg  <= 1'b0;
      seen   <= 1'b0;
      keySeq <= 1'b0;
    end else begin
      rxMsg  <= msgGo && !seen;
      seen   <= msgGo;
      keySeq <= keyGo;
    end
  end
endmodule

// ---- tb.sv ----
// self-checking bench of the configuration, serial framing and scan block
`timescale 1ns/100ps
module tb;
  logic        mclk = 1'b0, rstn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b1, arvalid = 1'b0, rready = 1'b1, runMode = 1'b0;
  logic        scanDone = 1'b0, txReq = 1'b0, expPresent = 1'b0, msgGo = 1'b0, keyGo = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, logicFromFlash, ioScanEn, scanStart;
  logic        rts, txGo, sessionActive, sessionDrop, memClear, expFault, startupDone, irq;
  logic        rxMsg, keySeq;
  logic [19:0] baudDiv;
  controller_config_sweep_pkg::sys_cfg_t    sysCfg;
  controller_config_sweep_pkg::serial_cfg_t serialCfg;
  int          err_total = 0, checked = 0, cyc = 0, g;
  int          rate [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
  logic [7:0]  ta [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h0C};
  logic [15:0] tw [10] = '{16'h0040, 16'h0060, 16'h0043, 16'h0058, 16'h0044, 16'h0004,
                           16'h0400, 16'h0401, 16'h0501, 16'h003D};
  logic [15:0] te [10] = '{16'h0040, 16'h0040, 16'h0040, 16'h0058, 16'h0044, 16'h0004,
                           16'h6400, 16'h6401, 16'h0501, 16'h000A};

  controller_config_serial_sweep #(.MODEM_UNIT_CYCLES(20), .SCAN_UNIT_CYCLES(50),
    .IDLE_UNIT_CYCLES(100), .DIAG_CYCLES(10)) DUT (.mclk, .rstn, .ce, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .runMode, .scanDone, .txReq, .rxMsg, .keySeq,
    .expPresent, .sysCfg, .serialCfg, .baudDiv, .logicFromFlash, .ioScanEn, .scanStart, .rts,
    .txGo, .sessionActive, .sessionDrop, .memClear, .expFault, .startupDone, .irq);
  prog_device DEV (.mclk, .rstn, .msgGo, .keyGo, .rxMsg, .keySeq);

  initial begin
    forever #2 mclk = ~mclk;
  end
  // scan work finishes at once, so start spacing shows only the pacing logic
  always @(posedge mclk) scanDone <= scanStart;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    fork
      begin
        @(posedge mclk iff awready);
        awvalid <= 1'b0;
      end
      begin
        @(posedge mclk iff wready);
        wvalid <= 1'b0;
      end
    join
    @(posedge mclk iff bvalid);
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    @(posedge mclk iff arready);
    arvalid <= 1'b0;
    @(posedge mclk iff rvalid);
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic gap(ref logic first, ref logic nxt);
    @(posedge mclk iff first);
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (!nxt);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    g = 0;
    repeat (20) begin
      @(posedge mclk);
      g += int'(memClear);
    end
    chk(32'(g), 32'd1);
    keyGo <= 1'b0;
    rd(8'h00, 32'h0000_0060, 2'h0);
    rd(8'h04, 32'h0000_001E, 2'h0);
    rd(8'h08, 32'h0000_0000, 2'h0);
    rd(8'h0C, 32'h0000_000A, 2'h0);
    rd(8'h10, 32'h0000_6400, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h40, 32'h0000_0001, 2'h2);
    for (int i = 0; i < 7; i++) begin
      d = {25'h0, i[0], 2'(i % 3), i[1], i[2:0]};
      wr(8'h04, d, 2'h0);
      rd(8'h04, d, 2'h0);
      chk(32'(baudDiv), 32'(250000000 / rate[i]));
    end
    wr(8'h04, 32'h0000_003F, 2'h0);
    rd(8'h04, d, 2'h0);
    foreach (ta[i]) begin
      wr(ta[i], 32'(tw[i]), 2'h0);
      rd(ta[i], 32'(te[i]), 2'h0);
    end
    chk(32'(ioScanEn), 32'd1);
    expPresent <= 1'b1;
    gap(scanStart, scanStart);
    chk(32'(g), 32'd250);
    chk(32'(expFault), 32'd1);
    wr(8'h10, 32'h0000_0500, 2'h0);
    gap(scanStart, scanStart);
    chk(32'(g), 32'd2);
    wr(8'h08, 32'h0000_0002, 2'h0);
    txReq <= 1'b1;
    gap(rts, txGo);
    chk(32'(g), 32'd41);
    txReq <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(rts), 32'd0);
    wr(8'h0C, 32'h0000_0001, 2'h0);
    wr(8'h18, 32'h0000_0001, 2'h0);
    chk(32'(irq), 32'd0);
    msgGo <= 1'b1;
    gap(sessionActive, sessionDrop);
    chk(32'(g), 32'd100);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'd1);
    rd(8'h14, 32'h0000_000D, 2'h0);
    rd(8'h20, 32'h0000_0022, 2'h0);
    wr(8'h1C, 32'h0000_0001, 2'h0);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'd0);
    rd(8'h14, 32'h0000_000C, 2'h0);
    msgGo <= 1'b0;
    results();
  end
endmodule
